// ---- common/pml_pkg.sv ----
`default_nettype none
package pml_pkg;
  // ----------------------------------------------------------------
  // Array shape
  // ----------------------------------------------------------------
  localparam int NCELL  = 32;
  localparam int NPT    = 5;
  localparam int NSM    = 40;
  localparam int NBLK   = 2;
  localparam int CPB    = NCELL / NBLK;
  localparam int CHAIN  = 8;
  localparam int REGION = 4;
  localparam int NGB    = 70;
  localparam int SEL_W  = 7;
  localparam int SIG_W  = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;

  // ----------------------------------------------------------------
  // Global bus positions
  // ----------------------------------------------------------------
  localparam int GB_GCK  = 32;
  localparam int GB_GCLR = 35;
  localparam int GB_OE   = 36;
  localparam int GB_FB   = 38;

  // ----------------------------------------------------------------
  // Byte addresses and cell word indices
  // ----------------------------------------------------------------
  localparam logic [15:0] CELL_END   = 16'h1000;
  localparam logic [15:0] SW_BASE    = 16'h1000;
  localparam logic [15:0] SW_END     = 16'h1140;
  localparam logic [15:0] SIG_ADDR   = 16'h1200;
  localparam logic [15:0] FUSE_ADDR  = 16'h1204;
  localparam logic [15:0] PINS_ADDR  = 16'h1208;
  localparam logic [15:0] CELLQ_ADDR = 16'h120C;
  localparam logic [4:0]  W_CTRL     = 5'h00;
  localparam logic [4:0]  W_PT_FIRST = 5'h04;
  localparam logic [4:0]  W_PT_LAST  = 5'h17;

  // ----------------------------------------------------------------
  // Cell control word fields
  // ----------------------------------------------------------------
  localparam int F_CLK  = 0;
  localparam int F_CE   = 2;
  localparam int F_CLR  = 3;
  localparam int F_SET  = 5;
  localparam int F_OREG = 6;
  localparam int F_FREG = 7;
  localparam int F_XOR  = 8;
  localparam int F_CASC = 9;
  localparam int F_PTM  = 10;
  localparam int F_FDM  = 15;
  localparam int F_FDS  = 19;
  localparam int F_OES  = 22;
  localparam int F_OEI  = 25;
  localparam int F_KEEP = 30;
  localparam int CTRL_W = 31;

  // Product term roles
  localparam int PT_CLK = 4;
  localparam int PT_CLR = 3;
  localparam int PT_SET = 2;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [30:0] CTRL_RST = 31'h00000000;
  localparam logic [15:0] SIG_RST  = 16'h0000;
  localparam logic [1:0]  CLK_PT   = 2'h3;

  typedef enum logic [1:0] {
    CLR_OFF  = 2'b00,
    CLR_GLB  = 2'b01,
    CLR_PT   = 2'b10,
    CLR_BOTH = 2'b11
  } pml_clr_type;

  typedef enum logic [2:0] {
    OE_OFF   = 3'b000,
    OE_ON    = 3'b001,
    OE_P0    = 3'b010,
    OE_P0N   = 3'b011,
    OE_P1    = 3'b100,
    OE_P1N   = 3'b101,
    OE_PIN   = 3'b110,
    OE_CELL  = 3'b111
  } pml_oe_type;
endpackage : pml_pkg
`default_nettype wire

// ---- design/pml_fabric.sv ----
// Summary of operation
// - Cell flip-flop loads data only on selected rising edge; clear and set act without an edge
// - Clock from three global lines or product term
// - Clock enable only with global clock selected
// - Enable low makes flip-flop ignore clock edges
// - Clear: global, term, both ORed, or off
// - Set: product term or off
// - Pin output registered or combinational, selectable
// - Feedback registered or combinational, chosen independently
// - Each pin input, output or bidirectional
// - Output enable from enable pins, pins, cells
// - Input pins keep all cell logic usable
// - Global bus holds pins and all feedbacks
// - Switch matrix picks forty bus signals per block
// - Each cell drives inverted product term foldback
// - Region foldbacks shared by four cells, nine terms
// - Four cascade chains, forty product terms each
// - Keeper holds last driven level of pin
// - Fuse hides configuration; signature always readable
`timescale 1ns/1ps
`default_nettype none
module pml_fabric (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [15:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Dedicated inputs
  input  wire logic [2:0]  global_clock_line_i,
  input  wire logic        global_clear_line_i,
  input  wire logic [1:0]  oe_pin_i,
  // Bidirectional pins
  input  wire logic [31:0] pin_i,
  input  wire logic [31:0] pin_ext_drive_i,
  output logic [31:0]      pin_o,
  output logic [31:0]      pin_oe_o,
  // Cell state
  output logic [31:0]      cell_q_o
);

  localparam int NC = pml_pkg::NCELL;
  localparam int NP = pml_pkg::NPT;
  localparam int NS = pml_pkg::NSM;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic pt_eval(input logic [39:0] in, input logic [39:0] t, input logic [39:0] c);
    pt_eval = (&(in | ~t)) & (&(~in | ~c));
  endfunction : pt_eval

  function automatic logic addr_hit(input logic [15:0] a);
    logic [4:0] w;
    w = a[6:2];
    addr_hit = 1'b0;
    if (a < pml_pkg::CELL_END)
      addr_hit = (w == pml_pkg::W_CTRL) || (w >= pml_pkg::W_PT_FIRST && w <= pml_pkg::W_PT_LAST);
    else if (a >= pml_pkg::SW_BASE && a < pml_pkg::SW_END)
      addr_hit = 1'b1;
    else if (a == pml_pkg::SIG_ADDR || a == pml_pkg::FUSE_ADDR)
      addr_hit = 1'b1;
    else if (a == pml_pkg::PINS_ADDR || a == pml_pkg::CELLQ_ADDR)
      addr_hit = 1'b1;
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  logic [30:0]    ctrl_r   [NC];
  logic [39:0]    pt_t_r   [NC][NP];
  logic [39:0]    pt_c_r   [NC][NP];
  logic [6:0]     sw_r     [pml_pkg::NBLK][NS];
  logic [15:0]    sig_r;
  logic           fuse_r;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [4:0]     a_cell;
  logic [4:0]     a_word;
  logic [2:0]     a_pt;
  logic [1:0]     a_part;
  logic [6:0]     a_swi;
  logic           a_blk;
  logic [5:0]     a_swj;
  logic           wr_en;
  logic           setup;

  assign a_cell = paddr_i[11:7];
  assign a_word = paddr_i[6:2];
  assign a_pt   = 3'(a_word[4:2] - 3'h1);
  assign a_part = a_word[1:0];
  assign a_swi  = 7'((paddr_i - pml_pkg::SW_BASE) >> 2);
  assign a_blk  = (a_swi >= 7'(NS));
  assign a_swj  = a_blk ? 6'(a_swi - 7'(NS)) : 6'(a_swi);
  assign wr_en  = psel_i && penable_i && pwrite_i && addr_hit(paddr_i);
  assign setup  = psel_i && !penable_i;

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int c = 0; c < NC; c++)
      begin
        ctrl_r[c] <= pml_pkg::CTRL_RST;
        for (int k = 0; k < NP; k++)
        begin
          pt_t_r[c][k] <= '0;
          pt_c_r[c][k] <= '0;
        end
      end
      for (int b = 0; b < pml_pkg::NBLK; b++)
        for (int j = 0; j < NS; j++)
          sw_r[b][j] <= '0;
    end
    else if (wr_en && paddr_i < pml_pkg::CELL_END)
    begin
      if (a_word == pml_pkg::W_CTRL)
        ctrl_r[a_cell] <= pwdata_i[30:0];
      else
        case (a_part)
          2'h0: pt_t_r[a_cell][a_pt][31:0]  <= pwdata_i;
          2'h1: pt_t_r[a_cell][a_pt][39:32] <= pwdata_i[7:0];
          2'h2: pt_c_r[a_cell][a_pt][31:0]  <= pwdata_i;
          default: pt_c_r[a_cell][a_pt][39:32] <= pwdata_i[7:0];
        endcase
    end
    else if (wr_en && paddr_i >= pml_pkg::SW_BASE && paddr_i < pml_pkg::SW_END)
      sw_r[a_blk][a_swj] <= pwdata_i[6:0];
  end

  // Signature and one-way fuse
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sig_r  <= pml_pkg::SIG_RST;
      fuse_r <= 1'b0;
    end
    else if (wr_en)
    begin
      if (paddr_i == pml_pkg::SIG_ADDR)
        sig_r <= pwdata_i[15:0];
      if (paddr_i == pml_pkg::FUSE_ADDR && pwdata_i[0])
        fuse_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0]    rd_nxt;
  logic [31:0]    rd_r;
  logic           err_r;
  logic [31:0]    q_r;
  logic [31:0]    pin_lvl;

  always_comb
  begin
    rd_nxt = '0;
    if (paddr_i < pml_pkg::CELL_END && !fuse_r)
    begin
      if (a_word == pml_pkg::W_CTRL)
        rd_nxt = {1'b0, ctrl_r[a_cell]};
      else if (a_word >= pml_pkg::W_PT_FIRST && a_word <= pml_pkg::W_PT_LAST)
        case (a_part)
          2'h0: rd_nxt = pt_t_r[a_cell][a_pt][31:0];
          2'h1: rd_nxt = {24'h000000, pt_t_r[a_cell][a_pt][39:32]};
          2'h2: rd_nxt = pt_c_r[a_cell][a_pt][31:0];
          default: rd_nxt = {24'h000000, pt_c_r[a_cell][a_pt][39:32]};
        endcase
    end
    else if (paddr_i >= pml_pkg::SW_BASE && paddr_i < pml_pkg::SW_END && !fuse_r)
      rd_nxt = {25'h0000000, sw_r[a_blk][a_swj]};
    else if (paddr_i == pml_pkg::SIG_ADDR)
      rd_nxt = {16'h0000, sig_r};
    else if (paddr_i == pml_pkg::FUSE_ADDR)
      rd_nxt = {31'h00000000, fuse_r};
    else if (paddr_i == pml_pkg::PINS_ADDR)
      rd_nxt = pin_lvl;
    else if (paddr_i == pml_pkg::CELLQ_ADDR)
      rd_nxt = q_r;
  end

  // Data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_r  <= '0;
      err_r <= 1'b0;
    end
    else if (setup)
    begin
      rd_r  <= pwrite_i ? 32'h00000000 : rd_nxt;
      err_r <= !addr_hit(paddr_i);
    end
  end

  assign prdata_o  = rd_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && err_r;

  // ----------------------------------------------------------------
  // Logic array
  // ----------------------------------------------------------------
  logic [69:0]    gbus;
  logic [39:0]    sm      [pml_pkg::NBLK];
  logic [4:0]     pt_v    [NC];
  logic [31:0]    fold;
  logic [31:0]    casc;
  logic [31:0]    comb_v;
  logic [31:0]    fb_v;
  logic [31:0]    fb_r;
  logic [31:0]    clk_lvl;
  logic [31:0]    clkp_r;
  logic [31:0]    ce_v;
  logic [31:0]    clr_v;
  logic [31:0]    set_v;
  logic [31:0]    oe_nxt;
  logic [31:0]    pin_o_r;
  logic [31:0]    oe_r;
  logic [31:0]    keep_r;
  logic [30:0]    cw;
  logic           sl;
  logic [3:0]     rfold;

  always_comb
  begin
    // Pin level seen inside; enable state never gates the cell logic
    for (int p = 0; p < NC; p++)
      if (oe_r[p])
        pin_lvl[p] = pin_o_r[p];
      else if (pin_ext_drive_i[p] || !ctrl_r[p][pml_pkg::F_KEEP])
        pin_lvl[p] = pin_i[p];
      else
        pin_lvl[p] = keep_r[p];
    gbus = '0;
    gbus[NC-1:0] = pin_lvl;
    gbus[pml_pkg::GB_GCK +: 3] = global_clock_line_i;
    gbus[pml_pkg::GB_GCLR] = global_clear_line_i;
    gbus[pml_pkg::GB_OE +: 2] = oe_pin_i;
    gbus[pml_pkg::GB_FB +: NC] = fb_r;
    for (int b = 0; b < pml_pkg::NBLK; b++)
      for (int j = 0; j < NS; j++)
        sm[b][j] = (sw_r[b][j] < 7'(pml_pkg::NGB)) ? gbus[sw_r[b][j]] : 1'b0;
    for (int c = 0; c < NC; c++)
    begin
      for (int k = 0; k < NP; k++)
        pt_v[c][k] = pt_eval(sm[c / pml_pkg::CPB], pt_t_r[c][k], pt_c_r[c][k]);
      cw = ctrl_r[c];
      fold[c] = (cw[pml_pkg::F_FDS +: 3] < 3'(NP)) ? !pt_v[c][cw[pml_pkg::F_FDS +: 3]] : 1'b1;
    end
    for (int c = 0; c < NC; c++)
    begin
      cw = ctrl_r[c];
      rfold = fold[(c / pml_pkg::REGION) * pml_pkg::REGION +: pml_pkg::REGION];
      sl = (|(pt_v[c] & cw[pml_pkg::F_PTM +: NP])) | (|(rfold & cw[pml_pkg::F_FDM +: 4]));
      if (c % pml_pkg::CHAIN != 0 && cw[pml_pkg::F_CASC])
        casc[c] = sl | casc[c-1];
      else
        casc[c] = sl;
      comb_v[c] = casc[c] ^ cw[pml_pkg::F_XOR];
      fb_v[c] = cw[pml_pkg::F_FREG] ? q_r[c] : comb_v[c];
      if (cw[pml_pkg::F_CLK +: 2] == pml_pkg::CLK_PT)
      begin
        clk_lvl[c] = pt_v[c][pml_pkg::PT_CLK];
        ce_v[c] = 1'b1;
      end
      else
      begin
        clk_lvl[c] = global_clock_line_i[cw[pml_pkg::F_CLK +: 2]];
        ce_v[c] = !cw[pml_pkg::F_CE] || pt_v[c][pml_pkg::PT_CLK];
      end
      case (pml_pkg::pml_clr_type'(cw[pml_pkg::F_CLR +: 2]))
        pml_pkg::CLR_GLB:  clr_v[c] = global_clear_line_i;
        pml_pkg::CLR_PT:   clr_v[c] = pt_v[c][pml_pkg::PT_CLR];
        pml_pkg::CLR_BOTH: clr_v[c] = global_clear_line_i | pt_v[c][pml_pkg::PT_CLR];
        default:           clr_v[c] = 1'b0;
      endcase
      set_v[c] = cw[pml_pkg::F_SET] && pt_v[c][pml_pkg::PT_SET];
      case (pml_pkg::pml_oe_type'(cw[pml_pkg::F_OES +: 3]))
        pml_pkg::OE_OFF:  oe_nxt[c] = 1'b0;
        pml_pkg::OE_ON:   oe_nxt[c] = 1'b1;
        pml_pkg::OE_P0:   oe_nxt[c] = oe_pin_i[0];
        pml_pkg::OE_P0N:  oe_nxt[c] = !oe_pin_i[0];
        pml_pkg::OE_P1:   oe_nxt[c] = oe_pin_i[1];
        pml_pkg::OE_P1N:  oe_nxt[c] = !oe_pin_i[1];
        pml_pkg::OE_PIN:  oe_nxt[c] = pin_lvl[cw[pml_pkg::F_OEI +: 5]];
        default:          oe_nxt[c] = fb_r[cw[pml_pkg::F_OEI +: 5]];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Cell flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q_r    <= '0;
      clkp_r <= '0;
    end
    else
      for (int c = 0; c < NC; c++)
      begin
        clkp_r[c] <= clk_lvl[c];
        if (clr_v[c])
          q_r[c] <= 1'b0;
        else if (set_v[c])
          q_r[c] <= 1'b1;
        else if (clk_lvl[c] && !clkp_r[c] && ce_v[c])
          q_r[c] <= comb_v[c];
      end
  end

  // Feedback registered once to break combinational loops
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fb_r <= '0;
    else
      fb_r <= fb_v;
  end

  // ----------------------------------------------------------------
  // Pin drivers and keepers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_o_r <= '0;
      oe_r    <= '0;
    end
    else
      for (int c = 0; c < NC; c++)
      begin
        pin_o_r[c] <= ctrl_r[c][pml_pkg::F_OREG] ? q_r[c] : comb_v[c];
        oe_r[c]    <= oe_nxt[c];
      end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      keep_r <= '0;
    else
      for (int p = 0; p < NC; p++)
        if (oe_r[p])
          keep_r[p] <= pin_o_r[p];
        else if (pin_ext_drive_i[p])
          keep_r[p] <= pin_i[p];
  end

  assign pin_o    = pin_o_r;
  assign pin_oe_o = oe_r;
  assign cell_q_o = q_r;

endmodule : pml_fabric
`default_nettype wire

// ---- verif/pml_fabric_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module pml_fabric_props (
  // Clock, reset and register bus
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Fabric outputs
  input wire logic [31:0] pin_oe_o,
  input wire logic [31:0] cell_q_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic        acc;
  logic [15:0] sig_r;
  logic        fuse_r;
  assign acc = psel_i && penable_i;
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sig_r <= pml_pkg::SIG_RST;
    else if (acc && pwrite_i && paddr_i == pml_pkg::SIG_ADDR)
      sig_r <= pwdata_i[15:0];
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fuse_r <= 1'h0;
    else if (acc && pwrite_i && paddr_i == pml_pkg::FUSE_ADDR && pwdata_i[0])
      fuse_r <= 1'h1;
  end
  sequence s_read(logic [15:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a ##1 acc;
  endsequence
  sequence s_cfg_read;
    psel_i && !penable_i && !pwrite_i && paddr_i < pml_pkg::SW_END ##1 acc;
  endsequence
  chk_zero_wait: assert property (psel_i |-> pready_o)
    else $error("pready low during a transfer");
  chk_err_phase: assert property (pslverr_o |-> acc)
    else $error("error flag outside access phase");
  chk_gap_error: assert property (acc && ((paddr_i >= pml_pkg::SW_END && paddr_i < pml_pkg::SIG_ADDR)
    || paddr_i > pml_pkg::CELLQ_ADDR) |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
    else $error("unmapped access not refused");
  chk_cfg_ok: assert property (acc && (paddr_i >= pml_pkg::SW_BASE && paddr_i < pml_pkg::SW_END
    || paddr_i < pml_pkg::CELL_END && (paddr_i[6:2] == pml_pkg::W_CTRL
    || paddr_i[6:2] >= pml_pkg::W_PT_FIRST && paddr_i[6:2] <= pml_pkg::W_PT_LAST)) |-> !pslverr_o)
    else $error("config access refused");
  chk_sig_kept: assert property (s_read(pml_pkg::SIG_ADDR) |-> prdata_o[15:0] == sig_r)
    else $error("signature readback wrong");
  chk_fuse_sticky: assert property (s_read(pml_pkg::FUSE_ADDR) |-> prdata_o[0] == fuse_r)
    else $error("fuse readback wrong");
  chk_fuse_hides: assert property (s_cfg_read |-> !fuse_r || prdata_o == 32'h0)
    else $error("config visible with fuse set");
  chk_q_readback: assert property (s_read(pml_pkg::CELLQ_ADDR) |-> prdata_o == $past(cell_q_o, 1))
    else $error("cell state readback wrong");
  chk_reset_quiet: assert property ($rose(rstn_i) |-> cell_q_o == 32'h0 && pin_oe_o == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : pml_fabric_props

bind pml_fabric pml_fabric_props u_props (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_oe_o(pin_oe_o), .cell_q_o(cell_q_o));
`default_nettype wire

// ---- verif/pml_board.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Board side of the pins
// ------------------------------------------------------------
module pml_board (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Device pin drivers
  input  wire logic [31:0] dev_out_i,
  input  wire logic [31:0] dev_oe_i,
  // Board drivers
  input  wire logic [31:0] drv_en_i,
  input  wire logic [31:0] drv_val_i,
  // Wire levels
  output logic [31:0]      line_o,
  output logic [31:0]      ext_drive_o
);
  logic [31:0] last_r;
  assign ext_drive_o = drv_en_i;
  // Floating line shows inverse of last driven level
  always_comb
  begin
    line_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & drv_en_i & drv_val_i) | (~dev_oe_i & ~drv_en_i & ~last_r);
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      last_r <= 32'h0;
    else
      last_r <= ((dev_oe_i | drv_en_i) & line_o) | (~dev_oe_i & ~drv_en_i & last_r);
  end
endmodule : pml_board
`default_nettype wire

// ---- verif/pml_fabric_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module pml_fabric_test;
  // ------------------------------------------------------------
  // Stimulus, wires and instances
  // ------------------------------------------------------------
  logic        clk  = 1'h0;
  logic        rstn = 1'h0;
  logic        psel = 1'h0;
  logic        pen  = 1'h0;
  logic        pwr  = 1'h0;
  logic [15:0] pa   = 16'h0000;
  logic [31:0] pwd  = 32'h0;
  logic [2:0]  global_clock_line  = 3'h0;
  logic        gclr = 1'h0;
  logic [1:0]  oep  = 2'h0;
  logic [31:0] den  = 32'h0;
  logic [31:0] dval = 32'h0;
  wire logic [31:0] prd, po, poe, plvl, pext, cq;
  wire logic        prdy, perr;
  int          num_errors = 0;
  int          num_checks = 0;
  localparam logic [31:0] C_REG = 32'h00400441;
  always #2.5 clk = ~clk;
  pml_fabric dut (.sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .global_clock_line_i(global_clock_line), .global_clear_line_i(gclr), .oe_pin_i(oep), .pin_i(plvl),
    .pin_ext_drive_i(pext), .pin_o(po), .pin_oe_o(poe), .cell_q_o(cq));
  pml_board board (.sys_clk_i(clk), .rstn_i(rstn), .dev_out_i(po), .dev_oe_i(poe),
    .drv_en_i(den), .drv_val_i(dval), .line_o(plvl), .ext_drive_o(pext));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'h1; pen <= 1'h0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'h1 && n < 50);
    if (prdy !== 1'h1)
    begin
      num_errors++;
      print_verdict();
    end
    else
    begin
      rd = prd;
      er = perr;
      psel <= 1'h0;
      pen <= 1'h0;
    end
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
    idle(3);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    check("read data", r & m, exp);
    check("read error", {31'h0, e}, {31'h0, eerr});
  endtask : rd
  task automatic pulse(input int which);
    if (which == 3) gclr <= 1'h1; else global_clock_line[which] <= 1'h1;
    idle(2);
    gclr <= 1'h0;
    global_clock_line <= 3'h0;
    idle(3);
  endtask : pulse
  function automatic logic oe_exp(input int c, input logic [1:0] p);
    logic [7:0] t;
    t = {1'h0, ~p[1], ~p[1], p[1], ~p[0], p[0], 1'h1, 1'h0};
    return t[c];
  endfunction : oe_exp
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    idle(3);
    rstn <= 1'h1;
    rd(16'h0000, 32'hFFFFFFFF, 32'h0, 1'h0);
    rd(16'h1140, 32'hFFFFFFFF, 32'h0, 1'h1);
    rd(16'h1210, 32'hFFFFFFFF, 32'h0, 1'h1);
    $display("test reset done");
    wr(16'h0000, C_REG);
    pulse(0);
    check("q other line", cq, 32'h0);
    pulse(1);
    check("q clocked", cq, 32'h1);
    check("pin reg", po & poe, 32'h1);
    rd(pml_pkg::CELLQ_ADDR, 32'hFFFFFFFF, 32'h1, 1'h0);
    wr(16'h0000, 32'h00400501);
    check("pin comb", po, 32'h0);
    check("q held", cq, 32'h1);
    $display("test clock done");
    for (int m = 0; m < 4; m++)
    begin
      wr(16'h0000, C_REG | (m << 3));
      pulse(1);
      check("q clear clk", cq, {31'h0, m < 2});
      pulse(3);
      check("q clear glb", cq, {31'h0, m == 0});
    end
    wr(16'h0000, C_REG | 32'h30);
    check("q clear wins", cq, 32'h0);
    wr(16'h0000, C_REG | 32'h20);
    check("q set", cq, 32'h1);
    $display("test clear set done");
    wr(pml_pkg::SW_BASE, 32'h24);
    wr(16'h0050, 32'h1);
    wr(16'h0000, 32'h0040044D);
    pulse(3);
    pulse(1);
    check("q enable low", cq, 32'h0);
    oep <= 2'h1;
    pulse(1);
    check("q enable high", cq, 32'h1);
    oep <= 2'h0;
    wr(16'h0000, 32'h0040044F);
    pulse(3);
    oep <= 2'h1;
    idle(3);
    check("q term clock", cq, 32'h1);
    $display("test enable done");
    den <= 32'h2;
    for (int p = 1; p < 3; p++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        oep <= 2'(p);
        dval <= 32'(p << 1) & 32'h2;
        wr(16'h0000, 32'h02000441 | (c << 22));
        check("oe select", poe, {31'h0, oe_exp(c, 2'(p))});
      end
    end
    $display("test enable select done");
    dval <= 32'h2;
    wr(16'h0080, 32'h40000000);
    den <= 32'h0;
    idle(3);
    rd(pml_pkg::PINS_ADDR, 32'h2, 32'h2, 1'h0);
    den <= 32'h2;
    wr(16'h0080, 32'h0);
    den <= 32'h0;
    idle(3);
    rd(pml_pkg::PINS_ADDR, 32'h2, 32'h0, 1'h0);
    $display("test keeper done");
    wr(16'h0080, 32'h00000201);
    wr(16'h0000, 32'h00200441);
    wr(16'h0100, 32'h00008001);
    oep <= 2'h0;
    pulse(1);
    check("q cascade", cq & 32'h2, 32'h2);
    check("q foldback", cq & 32'h4, 32'h4);
    oep <= 2'h1;
    pulse(1);
    check("q fold inverted", cq & 32'h7, 32'h3);
    $display("test fold done");
    wr(pml_pkg::SIG_ADDR, 32'h0000A5C3);
    wr(pml_pkg::FUSE_ADDR, 32'h1);
    rd(pml_pkg::FUSE_ADDR, 32'h1, 32'h1, 1'h0);
    rd(16'h0000, 32'hFFFFFFFF, 32'h0, 1'h0);
    rd(pml_pkg::SIG_ADDR, 32'hFFFF, 32'hA5C3, 1'h0);
    rstn <= 1'h0;
    idle(3);
    rstn <= 1'h1;
    rd(pml_pkg::FUSE_ADDR, 32'h1, 32'h0, 1'h0);
    $display("test fuse done");
    print_verdict();
  end
endmodule : pml_fabric_test
`default_nettype wire
